// ===== wdsr_map.svh
`ifndef WDSR_MAP_SVH
`define WDSR_MAP_SVH
// Register indices; the byte address is four times the index
`define WDSR_IDX_SMR      4'hb
`define WDSR_IDX_WDM      4'hf
// Reset values
`define WDSR_WDM_RST      8'h08
`define WDSR_SMR_RST      8'h00
`define WDSR_RDATA_RST    32'h0000_0000
// Write window: 60 processor cycles, two crystal clocks each
`define WDSR_WIN_PROC     60
`define WDSR_CRYSTAL_CLOCK_PER_PROC 2
`define WDSR_WIN_LAST     7'((`WDSR_WIN_PROC * `WDSR_CRYSTAL_CLOCK_PER_PROC) - 1)
`define WDSR_WIN_ZERO     7'h00
`define WDSR_WIN_ONE      7'h01
// Watchdog terminal counts in RC ticks, one per tap
`define WDSR_TERM0        16'h03ff
`define WDSR_TERM1        16'h0fff
`define WDSR_TERM2        16'h3fff
`define WDSR_TERM3        16'hffff
// Core reset hold after an internal reset, in crystal clocks
`define WDSR_DLY_SHORT    11'h00f
`define WDSR_DLY_LONG     11'h3ff
// Condition flags left by the refresh instruction: {z, s, v}
`define WDSR_REFRESH_FLAGS 3'h0
`endif

// ===== wdsr_pkg.sv
package wdsr_pkg;
    typedef struct packed {
        logic [3:0] rsvd;
        logic       stop_act;
        logic       halt_act;
        logic [1:0] tap;
    } wdsr_wdm_t;

    typedef struct packed {
        logic       rec_flag;
        logic       wake_pol;
        logic       long_dly;
        logic [2:0] src;
        logic       rsvd;
        logic       div16;
    } wdsr_smr_t;

    typedef enum logic [1:0] {
        WIN_WAIT   = 2'b00,
        WIN_OPEN   = 2'b01,
        WIN_CLOSED = 2'b10
    } wdsr_win_t;

    typedef struct packed {
        logic [1:0]  rc_sync;
        logic        rc_prev;
        logic [7:0]  wake_s1;
        logic [7:0]  wake_s2;
        logic        ack;
        logic [31:0] rdata;
        wdsr_wdm_t   wdm;
        wdsr_smr_t   stop_recovery_control;
        wdsr_win_t   win;
        logic [6:0]  win_cnt;
        logic        wdt_en;
        logic        strap_done;
        logic        strap;
        logic        flags_we;
        logic [2:0]  flags;
    } wdsr_top_st_t;
endpackage

// ===== wdsr_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdsr_ctl_if
    import wdsr_pkg::*;
    ();
    logic       rc_tick;
    logic       refresh;
    logic       wdt_en;
    wdsr_wdm_t  wdm;
    wdsr_smr_t  stop_recovery_control;
    logic       halt;
    logic       stop;
    logic [7:0] wake_lvl;
    logic       timeout;
    logic       core_reset;
    logic       rec_flag;
    modport top (output rc_tick, refresh, wdt_en, wdm, stop_recovery_control, halt, stop,
                 wake_lvl, input timeout, core_reset, rec_flag);
    modport wdt (input rc_tick, refresh, wdt_en, wdm, halt, stop,
                 core_reset, output timeout);
    modport rec (input stop_recovery_control, stop, wake_lvl, timeout,
                 output core_reset, rec_flag);
endinterface
`default_nettype wire

// ===== wdsr_wdt.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdsr_map.svh"
module wdsr_wdt
    import wdsr_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    wdsr_ctl_if.wdt   ctl
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        timeout;
    } wdsr_wdt_st_t;

    wdsr_wdt_st_t q;
    wdsr_wdt_st_t d;
    logic         gate;

    function automatic logic [15:0] term_of(input logic [1:0] tap);
        logic [15:0] t;
        unique case (tap)
            2'h0: t = `WDSR_TERM0;
            2'h1: t = `WDSR_TERM1;
            2'h2: t = `WDSR_TERM2;
            2'h3: t = `WDSR_TERM3;
        endcase
        return t;
    endfunction

    assign ctl.timeout = q.timeout;

    always_comb begin
        d = q;
        d.timeout = 1'b0;
        gate = ~(ctl.halt & ~ctl.wdm.halt_act)
             & ~(ctl.stop & ~ctl.wdm.stop_act);
        if (ctl.core_reset || !ctl.wdt_en || ctl.refresh) begin
            d.cnt = 16'h0000;
        end else if (ctl.rc_tick && gate) begin
            if (q.cnt == term_of(ctl.wdm.tap)) begin
                d.timeout = 1'b1;
                d.cnt = 16'h0000;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ===== wdsr_rec.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdsr_map.svh"
module wdsr_rec
    import wdsr_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    wdsr_ctl_if.rec   ctl
);
    typedef struct packed {
        logic        flag;
        logic        rst;
        logic [10:0] dly;
    } wdsr_rec_st_t;

    wdsr_rec_st_t q;
    wdsr_rec_st_t d;
    logic         wake;

    assign ctl.core_reset = q.rst;
    assign ctl.rec_flag   = q.flag;

    always_comb begin
        d = q;
        wake = ctl.stop & ~q.rst
             & (ctl.wake_lvl[ctl.stop_recovery_control.src] == ctl.stop_recovery_control.wake_pol);
        if (q.rst) begin
            if (q.dly == 11'h000) begin
                d.rst = 1'b0;
            end else begin
                d.dly = q.dly - 11'h001;
            end
        end else if (wake || ctl.timeout) begin
            d.rst = 1'b1;
            d.dly = (wake && ctl.stop_recovery_control.long_dly) ? `WDSR_DLY_LONG
                                               : `WDSR_DLY_SHORT;
        end
        if (wake) begin
            d.flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ===== wdsr_top.sv
// Function
// - Watchdog is a retriggerable one-shot that resets the core at terminal count.
// - Watchdog stays idle until the first refresh instruction enables it.
// - Each later refresh restarts the watchdog count from zero.
// - Watchdog counter advances on the on-chip RC oscillator.
// - Refresh instruction also updates the zero, sign and overflow flags.
// - Mode bits 1:0 select the counter tap setting the timeout.
// - Mode bit 2 keeps the watchdog counting during halt.
// - Mode bit 3 keeps the watchdog counting in stop; resets to one.
// - Mode bits 7:4 are reserved and do nothing.
// - Mode register writable only 120 clocks after first instruction.
// - After the window closes, mode writes are ignored until reset.
// - Mode register is write-only; reads return nothing useful.
// - One-time option lets the watchdog run straight after power-on.
// - Recovery register is write-only except read-only bit 7.
// - Bit 7 flag set by stop recovery, cleared only by power-on.
// - Bit 6 picks the wake level at the recovery source.
// - Bit 5 picks the reset delay length after recovery.
// - Bits 4:2 pick which source triggers stop recovery.
// - Bit 0 divides system and timer clocks by 16.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdsr_map.svh"
module wdsr_top
    import wdsr_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        refresh_in,
    input  wire logic        first_instr_in,
    input  wire logic        halt_in,
    input  wire logic        stop_in,
    input  wire logic        rc_clk_in,
    input  wire logic [7:0]  wake_src_in,
    input  wire logic        wdt_at_por_in,
    output logic             core_reset_out,
    output logic             flags_we_out,
    output logic      [2:0]  flags_out,
    output logic             clk_div16_out,
    output logic             wdt_running_out
);
    wdsr_top_st_t q;
    wdsr_top_st_t d;
    logic         req;
    logic         take;
    wdsr_ctl_if   ctl ();

    function automatic logic hit(input logic [3:0] a,
                                 input logic [3:0] idx);
        return a == idx;
    endfunction

    wdsr_wdt u_wdt (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .ctl        (ctl.wdt)
    );

    wdsr_rec u_rec (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .ctl        (ctl.rec)
    );

    assign req  = avs_read_in | avs_write_in;
    assign take = req & q.ack;

    // One wait state on every access
    assign avs_waitrequest_out = req & ~q.ack;
    assign avs_readdata_out    = q.rdata;

    assign ctl.rc_tick  = q.rc_sync[1] & ~q.rc_prev;
    assign ctl.refresh  = refresh_in;
    assign ctl.wdt_en   = q.wdt_en;
    assign ctl.wdm      = q.wdm;
    assign ctl.stop_recovery_control      = q.stop_recovery_control;
    assign ctl.halt     = halt_in;
    assign ctl.stop     = stop_in;
    assign ctl.wake_lvl = q.wake_s2;

    assign core_reset_out  = ctl.core_reset;
    assign flags_we_out    = q.flags_we;
    assign flags_out       = q.flags;
    assign clk_div16_out   = q.stop_recovery_control.div16;
    assign wdt_running_out = q.wdt_en;

    always_comb begin
        d = q;
        d.rc_sync  = {q.rc_sync[0], rc_clk_in};
        d.rc_prev  = q.rc_sync[1];
        d.wake_s1  = wake_src_in;
        d.wake_s2  = q.wake_s1;
        d.flags_we = 1'b0;
        d.ack      = req & ~q.ack;

        // Option strap is caught on the first clock after power-on
        if (!q.strap_done) begin
            d.strap_done = 1'b1;
            d.strap      = wdt_at_por_in;
            d.wdt_en     = wdt_at_por_in;
        end

        if (refresh_in) begin
            d.wdt_en   = 1'b1;
            d.flags_we = 1'b1;
            d.flags    = `WDSR_REFRESH_FLAGS;
        end

        if (avs_read_in && !q.ack) begin
            if (hit(avs_address_in, `WDSR_IDX_SMR)) begin
                d.rdata = {24'h00_0000, ctl.rec_flag, 7'h00};
            end else begin
                d.rdata = `WDSR_RDATA_RST;
            end
        end

        if (avs_write_in && take) begin
            if (hit(avs_address_in, `WDSR_IDX_WDM)
                && q.win == WIN_OPEN) begin
                d.wdm = avs_writedata_in[7:0];
            end
            if (hit(avs_address_in, `WDSR_IDX_SMR)) begin
                d.stop_recovery_control          = avs_writedata_in[7:0];
                d.stop_recovery_control.rec_flag = 1'b0;
                d.stop_recovery_control.rsvd     = 1'b0;
            end
        end

        unique case (q.win)
            WIN_WAIT: begin
                if (first_instr_in) begin
                    d.win     = WIN_OPEN;
                    d.win_cnt = `WDSR_WIN_ZERO;
                end
            end
            WIN_OPEN: begin
                d.win_cnt = q.win_cnt + `WDSR_WIN_ONE;
                if (q.win_cnt == `WDSR_WIN_LAST) begin
                    d.win = WIN_CLOSED;
                end
            end
            WIN_CLOSED: begin
                d.win = WIN_CLOSED;
            end
            default: begin
                d.win = WIN_WAIT;
            end
        endcase

        // Internal reset reopens the write window, restores the mode register and reloads the enable from the strap
        if (ctl.core_reset) begin
            d.win     = WIN_WAIT;
            d.win_cnt = `WDSR_WIN_ZERO;
            d.wdm     = `WDSR_WDM_RST;
            d.wdt_en  = q.strap;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q       <= '0;
            q.wdm   <= `WDSR_WDM_RST;
            q.stop_recovery_control   <= `WDSR_SMR_RST;
            q.rdata <= `WDSR_RDATA_RST;
            q.win   <= WIN_WAIT;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    refresh_enable_a: assert property (
        refresh_in && !ctl.core_reset |=> wdt_running_out)
        else $error("refresh did not enable the watchdog");

    refresh_flags_a: assert property (
        refresh_in |=> flags_we_out && flags_out == `WDSR_REFRESH_FLAGS)
        else $error("refresh did not update condition flags");

    refresh_clear_a: assert property (
        refresh_in |=> u_wdt.q.cnt == 16'h0000)
        else $error("refresh did not restart the count");

    halt_gate_a: assert property (
        halt_in && !q.wdm.halt_act && !refresh_in && !ctl.core_reset
        && q.wdt_en |=> $stable(u_wdt.q.cnt))
        else $error("watchdog counted in halt while disabled there");

    idle_count_a: assert property (
        !ctl.rc_tick && !refresh_in && q.wdt_en && !ctl.core_reset
        && !ctl.timeout |=> $stable(u_wdt.q.cnt))
        else $error("watchdog counted without an RC tick");

    tap_timeout_a: assert property (
        ctl.rc_tick && q.wdt_en && !refresh_in && !ctl.core_reset
        && !halt_in && !stop_in && q.wdm.tap == 2'h0
        && u_wdt.q.cnt == `WDSR_TERM0 |=> ctl.timeout)
        else $error("no timeout at the selected tap");

    timeout_reset_a: assert property (
        ctl.timeout && !ctl.core_reset |=> core_reset_out
        ##1 q.win == WIN_WAIT && q.wdm == `WDSR_WDM_RST)
        else $error("timeout did not reset core and reopen window");

    window_close_a: assert property (
        q.win == WIN_OPEN && q.win_cnt == `WDSR_WIN_LAST
        && !ctl.core_reset |=> q.win == WIN_CLOSED)
        else $error("write window did not close after 120 clocks");

    closed_hold_a: assert property (
        q.win == WIN_CLOSED && !ctl.core_reset |=> $stable(q.wdm))
        else $error("mode register changed after the window closed");

    mode_read_a: assert property (
        avs_read_in && !avs_waitrequest_out
        && hit(avs_address_in, `WDSR_IDX_WDM)
        |-> avs_readdata_out == `WDSR_RDATA_RST)
        else $error("mode register read returned data");

    flag_sticky_a: assert property (
        ctl.rec_flag |=> ctl.rec_flag)
        else $error("recovery flag cleared without power-on");

    wake_reset_a: assert property (
        stop_in && !core_reset_out
        && q.wake_s2[q.stop_recovery_control.src] == q.stop_recovery_control.wake_pol
        |=> core_reset_out && ctl.rec_flag)
        else $error("stop recovery did not start on matching level");

    long_delay_a: assert property (
        $rose(core_reset_out) && q.stop_recovery_control.long_dly && ctl.rec_flag
        && $past(stop_in) |-> core_reset_out [*8])
        else $error("long recovery delay ended early");

    div_follow_a: assert property (
        avs_write_in && take && hit(avs_address_in, `WDSR_IDX_SMR)
        |=> clk_div16_out == $past(avs_writedata_in[0]))
        else $error("divide-by-16 select not taken from write");

    bus_wait_a: assert property (
        req && !q.ack |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("access not answered after one wait state");
endmodule
`default_nettype wire

// ===== wdsr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdsr_core_model (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic core_reset_in,
    input  wire logic refresh_req_in,
    output logic      refresh_out,
    output logic      first_instr_out
);
    logic pend_q;

    // Core fetches its first instruction once each reset has ended
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pend_q          <= 1'h1;
            first_instr_out <= 1'h0;
            refresh_out     <= 1'h0;
        end else begin
            pend_q          <= core_reset_in;
            first_instr_out <= pend_q & ~core_reset_in;
            refresh_out     <= refresh_req_in & ~core_reset_in;
        end
    end
endmodule
`default_nettype wire

// ===== wdsr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdsr_map.svh"
module wdsr_top_tb;
    logic        clk   = 1'h0;
    logic        rst_b = 1'h0;
    logic        rc    = 1'h0;
    logic        rd    = 1'h0;
    logic        wr    = 1'h0;
    logic [3:0]  addr  = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        req   = 1'h0;
    logic        halt  = 1'h0;
    logic        stop  = 1'h0;
    logic        strap = 1'h0;
    logic [7:0]  wake  = 8'hff;
    logic [31:0] rdata;
    logic        waitreq, refresh, first_instr, core_rst;
    logic        flags_we, div16, running, pol, ld;
    logic [2:0]  flags;
    logic [31:0] r;
    logic [7:0]  b;
    bit          hit;
    int          bad_count, n_tests, cyc, len;

    initial begin
        forever #2.5 clk = ~clk;
    end
    // RC oscillator runs free and keeps ticking through stop
    initial begin
        forever #21.3 rc = ~rc;
    end

    wdsr_top dut (
        .sys_clk_in          (clk),
        .rst_b_in            (rst_b),
        .avs_address_in      (addr),
        .avs_read_in         (rd),
        .avs_write_in        (wr),
        .avs_writedata_in    (wdata),
        .avs_readdata_out    (rdata),
        .avs_waitrequest_out (waitreq),
        .refresh_in          (refresh),
        .first_instr_in      (first_instr),
        .halt_in             (halt),
        .stop_in             (stop),
        .rc_clk_in           (rc),
        .wake_src_in         (wake),
        .wdt_at_por_in       (strap),
        .core_reset_out      (core_rst),
        .flags_we_out        (flags_we),
        .flags_out           (flags),
        .clk_div16_out       (div16),
        .wdt_running_out     (running)
    );

    wdsr_core_model core (
        .clk_in          (clk),
        .rst_b_in        (rst_b),
        .core_reset_in   (core_rst),
        .refresh_req_in  (req),
        .refresh_out     (refresh),
        .first_instr_out (first_instr)
    );

    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic complete_run;
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One bus access; waitrequest and read data are looked at just before
    // each rising edge, so the edge that ends the wait is the one that takes
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int   n;
        logic ws;
        n  = 0;
        ws = 1'h1;
        addr  <= a;
        wdata <= {24'h0, d};
        wr    <= w;
        rd    <= ~w;
        while (ws !== 1'h0 && n < 40) begin
            @(negedge clk);
            ws = waitreq;
            r  = rdata;
            @(posedge clk);
            n++;
        end
        chk(n < 40, "bus hang");
        wr <= 1'h0;
        rd <= 1'h0;
        @(posedge clk);
    endtask

    task automatic do_refresh;
        req <= 1'h1;
        @(posedge clk);
        req <= 1'h0;
        @(posedge clk);
        #1;
        chk(running === 1'h1, "refresh enable");
        chk(flags_we === 1'h1 && flags === `WDSR_REFRESH_FLAGS, "flags");
        @(posedge clk);
    endtask

    // Waits n RC ticks, noting any core reset seen meanwhile
    task automatic ticks(input int n);
        hit = 1'h0;
        repeat (n) begin
            @(posedge rc);
            if (core_rst === 1'h1) hit = 1'h1;
        end
        @(posedge clk);
    endtask

    // Waits for a core reset, then measures how long it is held
    task automatic wait_rst(input int lim);
        hit = 1'h0;
        len = 0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge clk);
            hit = (core_rst === 1'h1);
        end
        if (hit) begin
            @(posedge clk);
            stop <= 1'h0;
            len = 1;
            @(negedge clk);
            while (core_rst === 1'h1 && len < 2000) begin
                len++;
                @(negedge clk);
            end
        end
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(32'h456d));
        repeat (12) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        chk(running === 1'h0, "idle before refresh");
        bus(1'h0, `WDSR_IDX_WDM, 8'h0);
        chk(r === 32'h0, "mode read");
        bus(1'h0, 4'h0, 8'h0);
        chk(r === 32'h0, "unmapped read");
        bus(1'h1, `WDSR_IDX_SMR, 8'h81);
        chk(div16 === 1'h1, "div16 on");
        bus(1'h0, `WDSR_IDX_SMR, 8'h0);
        chk(r === 32'h0, "flag written");
        bus(1'h1, `WDSR_IDX_SMR, 8'h00);
        chk(div16 === 1'h0, "div16 off");
        b = (8'($urandom) & 8'hf0) | 8'h08;
        bus(1'h1, `WDSR_IDX_WDM, b);
        do_refresh();
        halt <= 1'h1;
        ticks(1100);
        chk(!hit, "counted in halt");
        halt <= 1'h0;
        ticks(900);
        do_refresh();
        ticks(1000);
        chk(!hit, "retrigger");
        wait_rst(400);
        chk(hit, "timeout");
        chk(len == `WDSR_DLY_SHORT + 1, "reset length");
        chk(running === 1'h0, "enable after timeout");
        repeat (3) @(posedge clk);
        bus(1'h1, `WDSR_IDX_WDM, 8'h0c);
        repeat (130) @(posedge clk);
        bus(1'h1, `WDSR_IDX_WDM, 8'h0b);
        do_refresh();
        halt <= 1'h1;
        ticks(1000);
        chk(!hit, "early timeout");
        wait_rst(400);
        chk(hit, "late write taken");
        halt <= 1'h0;
        for (int s = 0; s < 8; s++) begin
            pol = 1'($urandom);
            ld  = (s < 2) ? 1'(s) : 1'($urandom);
            bus(1'h1, `WDSR_IDX_SMR, {1'h0, pol, ld, 3'(s), 2'h0});
            wake <= {8{~pol}};
            // Let the idle level pass the wake synchronisers before stop
            repeat (3) @(posedge clk);
            stop <= 1'h1;
            @(posedge clk);
            wake[(s + 1) % 8] <= pol;
            repeat (8) @(posedge clk);
            chk(core_rst === 1'h0, "wrong source woke");
            wake[s] <= pol;
            wait_rst(10);
            chk(hit, "stop recovery");
            b = ld ? 8'(`WDSR_DLY_LONG) : 8'(`WDSR_DLY_SHORT);
            chk(len == (ld ? `WDSR_DLY_LONG : `WDSR_DLY_SHORT) + 1, "delay");
            bus(1'h0, `WDSR_IDX_SMR, 8'h0);
            chk(r === 32'h80, "recovery flag");
        end
        strap <= 1'h1;
        rst_b <= 1'h0;
        repeat (12) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        chk(running === 1'h1, "run at power-on");
        bus(1'h0, `WDSR_IDX_SMR, 8'h0);
        chk(r === 32'h0, "flag after power-on");
        complete_run();
    end
endmodule
`default_nettype wire
